// ---- core/mric_core.sv ----
// reset values, interrupt flags, priority and acknowledge sequence with axi4-lite access
`include "mric_regs.svh"
module mric_core
    import mric_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external interrupt pins, asynchronous
    input wire logic ext_int0_n,
    input wire logic ext_int1,
    // peripheral pulses: timer a, b, c, zero cross, converter, serial
    input wire logic [5:0] periph_evt,
    // cpu core
    input wire mric_cpu_req_t cpu_req,
    output mric_ack_t ack_state,
    output logic [13:0] program_counter,
    output logic [9:0] stack_pointer,
    output logic branch_condition_flag,
    output logic global_irq_gate
);
    localparam logic [`MRIC_NMODE*16-1:0] WMASK = `MRIC_MODE_WMASK;
    localparam logic [5:0] MODE_W = 6'(`MRIC_A_MODE >> 2);

    function automatic int flag_pos(input int k);
        return (k == 7) ? 22 : 2 * k + 2;
    endfunction

    mric_ack_t state_q;
    logic [13:0] pc_q;
    logic [13:0] vec_q;
    logic [9:0] sp_q;
    logic st_q;
    logic ca_q;
    logic gate_q;
    logic [7:0] if_q;
    logic [7:0] im_q;
    logic [3:0] bitreg_q;
    logic [15:0] mode_q [`MRIC_NMODE];
    mric_frame_t stk_q [16];
    logic i0_meta_q, i0_sync_q, i0_prev_q;
    logic i1_meta_q, i1_sync_q, i1_prev_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;

    logic wr_go, wr_ok, rd_ok, idle, pop, any;
    logic int0_fall, int1_edge;
    logic [7:0] evt, req, if_clr, im_set, im_clr;
    logic [6:0] slot;
    logic [13:0] vec;
    logic [5:0] sp_up, ridx, widx;
    logic [23:0] bsel, bset, bclr, bits_rd;
    logic [31:0] rd;
    logic [15:0] irq_edge_mode_reg, lane;
    mric_frame_t top;

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign ack_state = state_q;
    assign program_counter = pc_q;
    assign stack_pointer = sp_q;
    assign branch_condition_flag = st_q;
    assign global_irq_gate = gate_q;

    // pins cross in through two flops before the edge detectors
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            i0_meta_q <= 1'b1;
            i0_sync_q <= 1'b1;
            i0_prev_q <= 1'b1;
            i1_meta_q <= 1'b0;
            i1_sync_q <= 1'b0;
            i1_prev_q <= 1'b0;
        end
        else
        begin
            i0_meta_q <= ext_int0_n;
            i0_sync_q <= i0_meta_q;
            i0_prev_q <= i0_sync_q;
            i1_meta_q <= ext_int1;
            i1_sync_q <= i1_meta_q;
            i1_prev_q <= i1_sync_q;
        end
    end

    // edge mode: bit 1 both edges, else bit 0 rising / falling
    assign irq_edge_mode_reg = mode_q[`MRIC_IDX_IMR];
    assign int0_fall = i0_prev_q & ~i0_sync_q;
    assign int1_edge = irq_edge_mode_reg[1] ? (i1_prev_q ^ i1_sync_q) :
        (irq_edge_mode_reg[0] ? (~i1_prev_q & i1_sync_q) : (i1_prev_q & ~i1_sync_q));
    assign evt = {periph_evt, int1_edge, int0_fall};

    assign req = if_q & ~im_q;
    assign slot = {req[7] | req[6], req[5:0]};

    mric_prio u_prio (
        .pend(slot),
        .any(any),
        .vector(vec)
    );

    // bit set/clear on the control nibbles
    assign wr_go = !awready_q && !wready_q && !bvalid_q;
    always_comb
    begin
        bsel = '0;
        case (awaddr_q)
            `MRIC_A_LOC0, `MRIC_A_LOC1, `MRIC_A_LOC2, `MRIC_A_LOC3:
                bsel[{1'b0, awaddr_q[3:2], wdata_q[1:0]}] = 1'b1;
            `MRIC_A_LOC20:
                bsel[{3'b100, wdata_q[1:0]}] = 1'b1;
            `MRIC_A_LOC23:
                bsel[{3'b101, wdata_q[1:0]}] = 1'b1;
            default:
                bsel = '0;
        endcase
    end
    assign bset = (wr_go && wstrb_q[0] && wdata_q[`MRIC_BIT_SET]) ? bsel : '0;
    assign bclr = (wr_go && wstrb_q[0] && !wdata_q[`MRIC_BIT_SET]) ? bsel : '0;

    for (genvar k = 0; k < 8; k++)
    begin : g_map
        assign if_clr[k] = bclr[flag_pos(k)];
        assign im_set[k] = bset[flag_pos(k) + 1];
        assign im_clr[k] = bclr[flag_pos(k) + 1];
    end

    always_comb
    begin
        bits_rd = '0;
        bits_rd[`MRIC_POS_GATE] = gate_q;
        bits_rd[19:16] = bitreg_q;
        for (int k = 0; k < 8; k++)
        begin
            bits_rd[flag_pos(k)] = if_q[k];
            bits_rd[flag_pos(k) + 1] = im_q[k];
        end
    end

    // a source event in the clearing cycle wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            if_q <= '0;
            im_q <= `MRIC_IM_RST;
        end
        else
        begin
            if_q <= (if_q & ~if_clr) | evt;
            im_q <= (im_q & ~im_clr) | im_set;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            gate_q <= 1'b0;
        else if (state_q == ACK_SAVE)
            gate_q <= 1'b0;
        else if (idle && cpu_req.reti)
            gate_q <= 1'b1;
        else if (bset[`MRIC_POS_GATE])
            gate_q <= 1'b1;
        else if (bclr[`MRIC_POS_GATE])
            gate_q <= 1'b0;
    end

    // watchdog run can only be set, direct switch only cleared
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            bitreg_q <= '0;
        else
            bitreg_q <= (bitreg_q & ~(bclr[19:16] & `MRIC_BR_CLR_OK)) | (bset[19:16] & `MRIC_BR_SET_OK);
    end

    assign widx = awaddr_q[7:2] - MODE_W;
    assign lane = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    for (genvar i = 0; i < `MRIC_NMODE; i++)
    begin : g_mode
        localparam logic [15:0] M = WMASK[i*16 +: 16];
        localparam logic [15:0] RV = (i == `MRIC_IDX_PORT_LATCH) ? `MRIC_PORT_LATCH_RST : 16'h0000;
        localparam logic [15:0] KEEP = (i == `MRIC_IDX_AMR) ? `MRIC_AMR_KEEP : 16'h0000;
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                mode_q[i] <= (mode_q[i] & KEEP) | RV;
            else if (wr_go && awaddr_q[7:2] >= MODE_W && widx == 6'(i))
                mode_q[i] <= (mode_q[i] & ~(lane & M)) | (wdata_q[15:0] & lane & M);
        end
    end

    // acknowledge sequence
    assign idle = state_q == ACK_IDLE;
    assign sp_up = sp_q[5:0] + `MRIC_SP_STEP;
    assign top = stk_q[sp_up[5:2]];
    assign pop = idle && (cpu_req.ret || cpu_req.reti);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_q <= ACK_IDLE;
        else
        begin
            case (state_q)
                ACK_IDLE:
                    if (gate_q && any)
                        state_q <= ACK_FINISH;
                ACK_FINISH:
                    state_q <= ACK_SAVE;
                ACK_SAVE:
                    state_q <= ACK_FETCH;
                ACK_FETCH:
                    state_q <= ACK_IDLE;
                default:
                    state_q <= ACK_IDLE;
            endcase
        end
    end

    // vector is frozen at acknowledge so a later request cannot redirect the fetch
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            vec_q <= `MRIC_VEC_BASE;
        else if (idle && gate_q && any)
            vec_q <= vec;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pc_q <= `MRIC_PC_RST;
        else if (state_q == ACK_FETCH)
            pc_q <= vec_q;
        else if (pop)
            pc_q <= top.pc;
        else if (state_q == ACK_FINISH || (idle && cpu_req.step))
            pc_q <= pc_q + 14'h0001;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sp_q <= `MRIC_SP_RST;
        else if (bclr[`MRIC_POS_RSP])
            sp_q <= `MRIC_SP_RST;
        else if (state_q == ACK_FETCH)
            sp_q <= {`MRIC_SP_TOP, sp_q[5:0] - `MRIC_SP_STEP};
        else if (pop)
            sp_q <= {`MRIC_SP_TOP, sp_up};
    end

    // overflow bit has no reset value; software sets it up
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_q <= `MRIC_ST_RST;
        else if (idle && cpu_req.reti)
            st_q <= top.st;
        else if (idle && cpu_req.st_wr)
            st_q <= cpu_req.st_val;
    end

    always_ff @(posedge aclk)
    begin
        if (idle && cpu_req.reti)
            ca_q <= top.ca;
        else if (idle && cpu_req.ca_wr)
            ca_q <= cpu_req.ca_val;
    end

    // stack memory takes no reset, so it survives a stop-exit reset
    always_ff @(posedge aclk)
    begin
        if (state_q == ACK_SAVE)
            stk_q[sp_q[5:2]] <= {ca_q, st_q, pc_q};
    end

    // axi write channels
    assign wr_ok = awaddr_q <= `MRIC_A_CORE || (awaddr_q[7:2] >= MODE_W && widx < 6'(`MRIC_NMODE));
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `MRIC_RESP_OKAY;
        end
        else if (wr_go)
        begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? `MRIC_RESP_OKAY : `MRIC_RESP_SLVERR;
        end
        else
        begin
            if (s_axi_awvalid && awready_q)
                awready_q <= 1'b0;
            if (s_axi_wvalid && wready_q)
                wready_q <= 1'b0;
            if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (s_axi_awvalid && awready_q)
            awaddr_q <= s_axi_awaddr;
        if (s_axi_wvalid && wready_q)
        begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
    end

    // axi read channels
    assign ridx = s_axi_araddr[7:2] - MODE_W;
    always_comb
    begin
        rd = '0;
        rd_ok = 1'b1;
        if (s_axi_araddr <= `MRIC_A_LOC3)
            rd[3:0] = bits_rd[{s_axi_araddr[3:2], 2'b00} +: 4];
        else if (s_axi_araddr == `MRIC_A_LOC20)
            rd[3:0] = bits_rd[19:16];
        else if (s_axi_araddr == `MRIC_A_LOC23)
            rd[3:0] = bits_rd[23:20];
        else if (s_axi_araddr == `MRIC_A_CORE)
            rd[25:0] = {ca_q, st_q, sp_q, pc_q};
        else if (s_axi_araddr[7:2] >= MODE_W && ridx < 6'(`MRIC_NMODE))
            rd[15:0] = mode_q[ridx[4:0]];
        else
            rd_ok = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `MRIC_RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd;
            rresp_q <= rd_ok ? `MRIC_RESP_OKAY : `MRIC_RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    core_reset_a:
    assert property ($rose(aresetn) |-> pc_q == `MRIC_PC_RST && st_q && sp_q == `MRIC_SP_RST)
        else $error("core state wrong after reset");
    irq_reset_a:
    assert property ($rose(aresetn) |-> !gate_q && if_q == 8'h00 && im_q == `MRIC_IM_RST)
        else $error("interrupt bits wrong after reset");
    port_reset_a:
    assert property ($rose(aresetn) |-> mode_q[0] == 16'hffff && mode_q[1] == 16'h0000)
        else $error("port latches wrong after reset");
    amr_keep_a:
    assert property ($rose(aresetn) |-> (mode_q[`MRIC_IDX_AMR] & ~`MRIC_AMR_KEEP) == 16'h0000)
        else $error("converter mode not cleared");
    bitreg_reset_a:
    assert property ($rose(aresetn) |-> bitreg_q == 4'h0)
        else $error("bit register not cleared");
    flag_source_a:
    assert property ((if_q & ~$past(if_q) & ~$past(evt)) == 8'h00)
        else $error("request flag set without event");
    ack_start_a:
    assert property (idle && gate_q && any |=> state_q == ACK_FINISH)
        else $error("pending request not acknowledged");
    ack_order_a:
    assert property (state_q == ACK_FINISH |=> state_q == ACK_SAVE ##1 state_q == ACK_FETCH ##1 idle)
        else $error("acknowledge sequence out of order");
    gate_clear_a:
    assert property (state_q == ACK_SAVE |=> !gate_q && $past(pc_q) == stk_q[$past(sp_q[5:2])].pc)
        else $error("gate or saved pc wrong in cycle two");
    vec_fetch_a:
    assert property (state_q == ACK_FETCH |=> pc_q == $past(vec_q) && pc_q[0] == 1'b0)
        else $error("fetch not from vector");
    sp_push_a:
    assert property (state_q == ACK_FETCH |=> sp_q[9:6] == `MRIC_SP_TOP && sp_q[5:0] == $past(sp_q[5:0]) - 6'h04)
        else $error("stack pointer push step wrong");
    reti_gate_a:
    assert property (idle && cpu_req.reti && !bclr[1] |=> gate_q && sp_q[5:0] == $past(sp_q[5:0]) + 6'h04)
        else $error("return did not restore gate");

    ack_seen_c: cover property (state_q == ACK_FINISH ##3 idle);
    shared_vec_c: cover property (idle && gate_q && slot == 7'h40 && req[7] && req[6]);
    nest_c: cover property (state_q == ACK_FETCH && sp_q[5:2] == 4'he);
    reti_c: cover property (idle && cpu_req.reti && !gate_q);
endmodule // mric_core

// ---- core/mric_pkg.sv ----
// types shared by the reset/interrupt block
package mric_pkg;
    typedef enum logic [3:0] {
        ACK_IDLE = 4'h1,
        ACK_FINISH = 4'h2,
        ACK_SAVE = 4'h4,
        ACK_FETCH = 4'h8
    } mric_ack_t;

    typedef struct packed {
        logic step;
        logic ret;
        logic reti;
        logic st_wr;
        logic st_val;
        logic ca_wr;
        logic ca_val;
    } mric_cpu_req_t;

    typedef struct packed {
        logic ca;
        logic st;
        logic [13:0] pc;
    } mric_frame_t;
endpackage

// ---- core/mric_prio.sv ----
// fixed-priority vector encoder over the seven interrupt vectors
`include "mric_regs.svh"
module mric_prio
    import mric_pkg::*;
(
    // pending requests, slot 0 highest
    input wire logic [6:0] pend,
    // selected vector
    output logic any,
    output logic [13:0] vector
);
    always_comb
    begin
        any = |pend;
        vector = `MRIC_VEC_BASE;
        for (int i = 6; i >= 0; i--)
        begin
            if (pend[i])
            begin
                vector = `MRIC_VEC_BASE + 14'(2 * i);
            end
        end
    end
endmodule // mric_prio

// ---- core/mric_regs.svh ----
// offsets, field positions, reset values and vectors of the reset/interrupt block
`ifndef MRIC_REGS_SVH
`define MRIC_REGS_SVH
`define MRIC_A_LOC0 8'h00
`define MRIC_A_LOC1 8'h04
`define MRIC_A_LOC2 8'h08
`define MRIC_A_LOC3 8'h0c
`define MRIC_A_LOC20 8'h10
`define MRIC_A_LOC23 8'h14
`define MRIC_A_CORE 8'h18
`define MRIC_A_MODE 8'h40
`define MRIC_NMODE 23
`define MRIC_IDX_PORT_LATCH 0
`define MRIC_IDX_IMR 5
`define MRIC_IDX_AMR 19
`define MRIC_MODE_WMASK {16'h000f, 16'h000f, 16'h0007, 16'h000f, 16'h0007, 16'h00ff, 16'h00ff, \
    16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h0fff, 16'h000f, 16'h000f, 16'h000f, 16'h000f, \
    16'h000f, 16'h000f, 16'h000f, 16'h0003, 16'h000f, 16'hffff, 16'hffff}
`define MRIC_PORT_LATCH_RST 16'hffff
`define MRIC_AMR_KEEP 16'h0002
`define MRIC_BIT_SET 4
`define MRIC_BR_SET_OK 4'h7
`define MRIC_BR_CLR_OK 4'hd
`define MRIC_POS_GATE 0
`define MRIC_POS_RSP 1
`define MRIC_IM_RST 8'hff
`define MRIC_PC_RST 14'h0000
`define MRIC_ST_RST 1'b1
`define MRIC_SP_RST 10'h3ff
`define MRIC_SP_TOP 4'hf
`define MRIC_SP_STEP 6'h04
`define MRIC_VEC_BASE 14'h0002
`define MRIC_RESP_OKAY 2'b00
`define MRIC_RESP_SLVERR 2'b10
`endif

// ---- verif/mric_cpu_model.sv ----
// cpu core and peripheral event sources facing the reset/interrupt block
module mric_cpu_model
    import mric_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // commands from the bench
    input wire logic [5:0] evt_cmd,
    input wire logic reti_cmd,
    // block side
    input wire mric_ack_t ack_state,
    output logic [5:0] periph_evt,
    output mric_cpu_req_t cpu_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic init_q;
    initial
    begin
        periph_evt = 6'h00;
        cpu_req = '0;
        init_q = 1'b0;
    end
    // each event command is passed on one cycle later as it stands; fire holds it for a single cycle, as real sources give
    always @(posedge aclk)
    begin
        periph_evt <= evt_cmd;
    end
    always @(posedge aclk)
    begin
        init_q <= aresetn;
        // overflow bit is undefined after reset, so software clears it once
        // handler returns only once the acknowledge sequence is over
        cpu_req <= '{step: 1'b0, ret: 1'b0, reti: reti_cmd && ack_state == ACK_IDLE, st_wr: 1'b0,
            st_val: 1'b0, ca_wr: aresetn && !init_q, ca_val: 1'b0};
    end
endmodule // mric_cpu_model

// ---- verif/tb_mcu_reset_and_interrupt_control.sv ----
// self-checking bench for the reset and interrupt control block
module tb_mcu_reset_and_interrupt_control
    import mric_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] wd;
        logic [1:0] rs;
        logic [31:0] rd;
    } mric_row_t;
    localparam mric_row_t ROWS [13] = '{
        '{8'h40, 32'h0, 2'h0, 32'h0}, '{8'h44, 32'h1234, 2'h0, 32'h1234},
        '{8'h4c, 32'hffff, 2'h0, 32'h3}, '{8'h6c, 32'hffff, 2'h0, 32'hfff},
        '{8'h70, 32'hffff, 2'h0, 32'hff}, '{8'h88, 32'hff, 2'h0, 32'h7},
        '{8'h90, 32'hff, 2'h0, 32'h7}, '{8'h00, 32'h14, 2'h0, 32'h9},
        '{8'h00, 32'h11, 2'h0, 32'h9}, '{8'h00, 32'h00, 2'h0, 32'h8},
        '{8'h14, 32'h16, 2'h0, 32'h8}, '{8'h1c, 32'h1, 2'h2, 32'h0},
        '{8'h9c, 32'h1, 2'h2, 32'h0}};
    localparam logic [7:0] SRC_A [8] = '{8'h00, 8'h04, 8'h04, 8'h08, 8'h08, 8'h0c, 8'h0c, 8'h14};
    localparam logic [1:0] SRC_FB [8] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0, 2'h2, 2'h2};
    localparam logic [3:0] RST_NIB [6] = '{4'h8, 4'ha, 4'ha, 4'ha, 4'h0, 4'h8};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic ext_int0_n = 1'b1;
    logic ext_int1 = 1'b1;
    logic [5:0] evt_cmd = 6'h00;
    logic reti_cmd = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, branch_condition_flag, global_irq_gate;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [5:0] periph_evt;
    logic [13:0] program_counter;
    logic [9:0] stack_pointer;
    mric_cpu_req_t cpu_req;
    mric_ack_t ack_state;
    int fail_count = 0;
    int cmp_count = 0;

    mric_core i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_int0_n(ext_int0_n),
        .ext_int1(ext_int1), .periph_evt(periph_evt), .cpu_req(cpu_req), .ack_state(ack_state),
        .program_counter(program_counter), .stack_pointer(stack_pointer),
        .branch_condition_flag(branch_condition_flag), .global_irq_gate(global_irq_gate));
    mric_cpu_model i_cpu (.aclk(aclk), .aresetn(aresetn), .evt_cmd(evt_cmd), .reti_cmd(reti_cmd),
        .ack_state(ack_state), .periph_evt(periph_evt), .cpu_req(cpu_req));

    initial
    begin
        forever #2 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ready and valid are registered, so the level at the falling edge is what the next rising edge sees
    // bready stays high between writes, so back-to-back calls never toggle it in one step
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ah, wh, bh;
        logic [1:0] r;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ah)
                awvalid <= 1'b0;
            if (wh)
                wvalid <= 1'b0;
        end while (!bh);
        check(r, er);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
        logic ah, bh;
        logic [31:0] d;
        logic [1:0] r;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ah = arvalid && arready;
            bh = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ah)
                arvalid <= 1'b0;
        end while (!bh);
        check(d & m, exp);
        check(r, er);
    endtask

    task automatic chk_reset;
        int i;
        check({program_counter, stack_pointer, branch_condition_flag, global_irq_gate}, {14'h0, 10'h3ff, 2'b10});
        for (i = 0; i < 6; i++)
            rd_chk(8'(i * 4), {28'h0, RST_NIB[i]}, 32'hffffffff, 2'h0);
        // converter mode keeps its undefined bit over reset
        for (i = 0; i < 23; i++)
            rd_chk(8'(64 + i * 4), i == 0 ? 32'hffff : 32'h0, i == 19 ? 32'hfffffffd : 32'hffffffff, 2'h0);
        rd_chk(8'h18, {7'h0, 1'b1, 10'h3ff, 14'h0}, 32'h03ffffff, 2'h0);
    endtask

    task automatic fire(input logic [7:0] m);
        ext_int0_n <= !m[0];
        ext_int1 <= !m[1];
        evt_cmd <= m[7:2];
        @(posedge aclk);
        ext_int0_n <= 1'b1;
        ext_int1 <= 1'b1;
        evt_cmd <= 6'h00;
        // lets the pin synchroniser settle
        repeat (6) @(posedge aclk);
    endtask

    task automatic take(input logic [13:0] vec);
        int n;
        n = 0;
        while (ack_state !== ACK_FINISH && n < 20)
        begin
            @(negedge aclk);
            n++;
        end
        @(negedge aclk);
        check(ack_state, ACK_SAVE);
        @(negedge aclk);
        check(ack_state, ACK_FETCH);
        check(global_irq_gate, 32'h0);
        @(negedge aclk);
        check(ack_state, ACK_IDLE);
        check(program_counter, vec);
        check(stack_pointer, 32'h3fb);
        @(posedge aclk);
    endtask

    task automatic ret_irq(input int s);
        int n;
        axi_wr(SRC_A[s], 32'(SRC_FB[s]), 2'h0);
        axi_wr(SRC_A[s], 32'(SRC_FB[s]) + 32'd17, 2'h0);
        reti_cmd <= 1'b1;
        @(posedge aclk);
        reti_cmd <= 1'b0;
        n = 0;
        while (global_irq_gate !== 1'b1 && n < 10)
        begin
            @(negedge aclk);
            n++;
        end
        check(global_irq_gate, 32'h1);
        check(branch_condition_flag, 32'h1);
        check(stack_pointer, 32'h3ff);
        @(posedge aclk);
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        finish_test();
    end

    initial
    begin
        int i;
        int s;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_reset();
        for (i = 0; i < 13; i++)
        begin
            axi_wr(ROWS[i].a, ROWS[i].wd, ROWS[i].rs);
            rd_chk(ROWS[i].a, ROWS[i].rd, 32'hffffffff, ROWS[i].rs);
        end
        for (s = 0; s < 8; s++)
        begin
            fire(8'(1 << s));
            rd_chk(SRC_A[s], 32'h1 << SRC_FB[s], 32'h1 << SRC_FB[s], 2'h0);
            // gate open but source still masked: nothing may start
            axi_wr(8'h00, 32'h10, 2'h0);
            repeat (8) @(negedge aclk);
            check(ack_state, ACK_IDLE);
            @(posedge aclk);
            axi_wr(SRC_A[s], 32'(SRC_FB[s]) + 32'd1, 2'h0);
            take(s < 7 ? 14'(2 * s + 2) : 14'h00e);
            ret_irq(s);
        end
        // timer a and timer c together: the higher one wins, the other follows on return
        fire(8'h14);
        // gate shut first, else timer a is taken before timer c is unmasked
        axi_wr(8'h00, 32'h0, 2'h0);
        axi_wr(8'h04, 32'h3, 2'h0);
        axi_wr(8'h08, 32'h3, 2'h0);
        axi_wr(8'h00, 32'h10, 2'h0);
        take(14'h006);
        ret_irq(2);
        take(14'h00a);
        ret_irq(4);
        // second reset with a request pending and the gate open
        fire(8'h08);
        axi_wr(8'h00, 32'h10, 2'h0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_reset();
        finish_test();
    end
endmodule // tb_mcu_reset_and_interrupt_control
